/* include/gs_pkg.sv */
// constants for the geometry stage front end
// assumes a 32-bit command dword stream and 32-bit apb
package gs_pkg;
   // apb register byte offsets
   localparam logic [7:0] reg_control = 8'h00;
   localparam logic [7:0] reg_status = 8'h04;
   localparam logic [7:0] reg_index_base = 8'h10;
   localparam logic [7:0] reg_max_index = 8'h20;
   localparam logic [7:0] reg_kernel = 8'h24;
   localparam logic [7:0] reg_flags = 8'h28;
   localparam logic [7:0] reg_scratch = 8'h2c;
   localparam logic [7:0] reg_const_len = 8'h30;
   // command header fields
   localparam logic [2:0] cmd_type_3d = 3'h3;
   localparam logic [1:0] cmd_subtype_3d = 2'h3;
   localparam logic [2:0] cmd_opcode_np = 3'h1;
   localparam logic [7:0] cmd_sub_index = 8'h0b;
   localparam int cmd_len_bias = 2;
   // state block fields
   localparam int kernel_lsb = 6;
   localparam int regcnt_lsb = 1;
   localparam int single_flow_bit = 31;
   localparam int bind_lsb = 18;
   localparam int prio_bit = 17;
   localparam int float_bit = 16;
   localparam int ex_illegal_bit = 13;
   localparam int ex_stack_bit = 11;
   localparam int ex_soft_bit = 7;
   localparam int cr_illegal_bit = 12;
   localparam int cr_stack_bit = 11;
   localparam int cr_soft_bit = 13;
   localparam int scratch_lsb = 10;
   localparam logic [3:0] scratch_max_code = 4'hb;
   localparam int const_len_lsb = 25;
   localparam int regs_per_block = 16;
   localparam logic [31:0] control_reset = 32'h0000_0000;
endpackage

/* logic/gs_index_load.sv */
// decoder of the streamed vertex index load command
// assumes dwords arrive in order with a valid strobe
`timescale 1ns/1ps
module gs_index_load
   import gs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic dw_valid,
   input wire logic [31:0] dw_data,
   input wire logic pipe_idle,
   output logic flush_req,
   output logic load_valid,
   output logic [1:0] load_sel,
   output logic [31:0] load_value,
   output logic max_valid,
   output logic [31:0] max_value,
   output logic bad_cmd
);
   typedef enum logic [4:0] {
      s_head = 5'b00001, s_sel = 5'b00010, s_val = 5'b00100, s_max = 5'b01000, s_flush = 5'b10000
   } ld_state_type;
   ld_state_type state;
   logic [7:0] len;
   logic [1:0] sel;
   logic [31:0] value;
   logic has_max;
   wire hdr_match = dw_data[31:29] == cmd_type_3d && dw_data[28:27] == cmd_subtype_3d
      && dw_data[26:24] == cmd_opcode_np && dw_data[23:16] == cmd_sub_index;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= s_head;
         len <= 8'h00;
         sel <= 2'h0;
         value <= 32'h0000_0000;
         has_max <= 1'b0;
         flush_req <= 1'b0;
         load_valid <= 1'b0;
         load_sel <= 2'h0;
         load_value <= 32'h0000_0000;
         max_valid <= 1'b0;
         max_value <= 32'h0000_0000;
         bad_cmd <= 1'b0;
      end else if (ce) begin
         load_valid <= 1'b0;
         max_valid <= 1'b0;
         bad_cmd <= 1'b0;
         case (state)
            s_head: begin
               if (dw_valid) begin
                  if (hdr_match) begin
                     len <= dw_data[7:0];
                     has_max <= dw_data[7:0] >= 8'h02;
                     state <= s_sel;
                  end else begin
                     bad_cmd <= 1'b1;
                  end
               end
            end
            s_sel: begin
               if (dw_valid) begin
                  sel <= dw_data[30:29];
                  state <= s_val;
               end
            end
            s_val: begin
               if (dw_valid) begin
                  value <= dw_data;
                  state <= has_max ? s_max : s_flush;
                  flush_req <= !has_max;
               end
            end
            s_max: begin
               if (dw_valid) begin
                  max_value <= dw_data;
                  max_valid <= 1'b1;
                  flush_req <= 1'b1;
                  state <= s_flush;
               end
            end
            s_flush: begin
               if (pipe_idle) begin
                  flush_req <= 1'b0;
                  load_valid <= 1'b1;
                  load_sel <= sel;
                  load_value <= value;
                  state <= s_head;
               end
            end
            default: state <= s_head;
         endcase
      end
   end
endmodule

/* logic/geometry_state_block_decode.sv */
// field extraction for the geometry state block
// assumes four state dwords presented together
`timescale 1ns/1ps
module geometry_state_block_decode
   import gs_pkg::*;
(
   input wire logic [31:0] dw0,
   input wire logic [31:0] dw1,
   input wire logic [31:0] dw2,
   input wire logic [31:0] dw3,
   output logic [25:0] kernel_ptr,
   output logic [7:0] reg_count,
   output logic flow_ok,
   output logic [7:0] bind_count,
   output logic high_prio,
   output logic alt_float,
   output logic [15:0] cr_exc,
   output logic [21:0] scratch_base,
   output logic [21:0] scratch_kb,
   output logic [5:0] const_len
);
   assign kernel_ptr = dw0[31:kernel_lsb];
   assign reg_count = 8'((dw0[3:regcnt_lsb] + 4'h1) * regs_per_block);
   assign flow_ok = dw1[single_flow_bit];
   assign bind_count = dw1[bind_lsb+7:bind_lsb];
   assign high_prio = dw1[prio_bit];
   assign alt_float = dw1[float_bit];
   always_comb begin
      cr_exc = 16'h0000;
      cr_exc[cr_illegal_bit] = dw1[ex_illegal_bit];
      cr_exc[cr_stack_bit] = dw1[ex_stack_bit];
      cr_exc[cr_soft_bit] = dw1[ex_soft_bit];
   end
   assign scratch_base = dw2[31:scratch_lsb];
   assign scratch_kb = (dw2[3:0] <= scratch_max_code) ? (22'h1 << dw2[3:0]) : 22'h0;
   assign const_len = dw3[const_len_lsb+5:const_len_lsb];
endmodule

/* logic/gs_front.sv */
// geometry stage front end: vertex assembly, pass-through, state and index registers
// assumes an apb master, a command dword stream and a vertex stream from the vertex stage
`timescale 1ns/1ps
module gs_front
   import gs_pkg::*;
#(
   parameter int verts_per_object = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmd_valid,
   input wire logic [31:0] cmd_data,
   input wire logic vtx_valid,
   input wire logic [31:0] vtx_handle,
   input wire logic [31:0] vtx_header,
   output logic clipping_stage_valid,
   output logic [31:0] clipping_stage_handle,
   output logic [31:0] clipping_stage_header,
   output logic spawn_valid,
   output logic [31:0] spawn_handle0,
   output logic [31:0] spawn_handle1,
   output logic [31:0] spawn_handle2,
   output logic [31:0] spawn_kernel,
   output logic [15:0] spawn_cr,
   output logic spawn_high_prio,
   output logic spawn_alt_float,
   output logic [5:0] spawn_const_len,
   output logic [127:0] spawn_indices
);
   // ***************************
   // registers and apb decode
   // ***************************
   logic [31:0] control;
   logic [31:0] index [4];
   logic [31:0] max_index;
   logic [31:0] st0, st1, st2, st3;
   logic [7:0] status_bits;
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire hit_ctrl = paddr == reg_control;
   wire hit_stat = paddr == reg_status;
   wire hit_idx = paddr[7:4] == reg_index_base[7:4] && paddr[1:0] == 2'h0;
   wire hit_max = paddr == reg_max_index;
   wire hit_k = paddr == reg_kernel;
   wire hit_f = paddr == reg_flags;
   wire hit_s = paddr == reg_scratch;
   wire hit_c = paddr == reg_const_len;
   wire mapped = hit_ctrl || hit_stat || hit_idx || hit_max || hit_k || hit_f || hit_s || hit_c;
   wire [31:0] rd_mux = hit_ctrl ? control : hit_stat ? {24'h0, status_bits} :
      hit_idx ? index[paddr[3:2]] : hit_max ? max_index : hit_k ? st0 : hit_f ? st1 :
      hit_s ? st2 : hit_c ? st3 : 32'h0000_0000;
   wire enabled = control[0];
   // ***************************
   // index load command
   // ***************************
   logic flush_req, load_valid, max_valid, bad_cmd;
   logic [1:0] load_sel;
   logic [31:0] load_value, max_value;
   logic busy;
   gs_index_load u_load (
      .pclk(pclk), .presetn(presetn), .ce(ce), .dw_valid(cmd_valid), .dw_data(cmd_data),
      .pipe_idle(!busy), .flush_req(flush_req), .load_valid(load_valid), .load_sel(load_sel),
      .load_value(load_value), .max_valid(max_valid), .max_value(max_value), .bad_cmd(bad_cmd)
   );
   // ***************************
   // state decode
   // ***************************
   logic [25:0] kernel_ptr;
   logic [7:0] reg_count, bind_count;
   logic flow_ok, high_prio, alt_float;
   logic [15:0] cr_exc;
   logic [21:0] scratch_base, scratch_kb;
   logic [5:0] const_len;
   geometry_state_block_decode u_dec (
      .dw0(st0), .dw1(st1), .dw2(st2), .dw3(st3), .kernel_ptr(kernel_ptr), .reg_count(reg_count),
      .flow_ok(flow_ok), .bind_count(bind_count), .high_prio(high_prio), .alt_float(alt_float),
      .cr_exc(cr_exc), .scratch_base(scratch_base), .scratch_kb(scratch_kb), .const_len(const_len)
   );
   assign status_bits = {4'h0, bad_cmd, flush_req, flow_ok, busy};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= control_reset;
         max_index <= 32'h0000_0000;
         st0 <= 32'h0000_0000;
         st1 <= 32'h0000_0000;
         st2 <= 32'h0000_0000;
         st3 <= 32'h0000_0000;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
         prdata <= (access && !pwrite && !pready) ? rd_mux : 32'h0000_0000;
         if (wr && !pready && hit_ctrl) begin
            control <= pwdata;
         end
         if (wr && !pready && hit_k) begin
            st0 <= pwdata;
         end
         if (wr && !pready && hit_f) begin
            st1 <= pwdata;
         end
         if (wr && !pready && hit_s) begin
            st2 <= pwdata;
         end
         if (wr && !pready && hit_c) begin
            st3 <= pwdata;
         end
         if (max_valid) begin
            max_index <= max_value;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            index[i] <= 32'h0000_0000;
         end
      end else if (ce && load_valid) begin
         index[load_sel] <= load_value;
      end
   end
   // ***************************
   // vertex assembly and pass-through
   // ***************************
   logic [1:0] vcount;
   logic [31:0] hold0, hold1;
   wire last_vtx = vcount == 2'(verts_per_object - 1);
   assign busy = vcount != 2'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vcount <= 2'h0;
         hold0 <= 32'h0000_0000;
         hold1 <= 32'h0000_0000;
         clipping_stage_valid <= 1'b0;
         clipping_stage_handle <= 32'h0000_0000;
         clipping_stage_header <= 32'h0000_0000;
         spawn_valid <= 1'b0;
         spawn_handle0 <= 32'h0000_0000;
         spawn_handle1 <= 32'h0000_0000;
         spawn_handle2 <= 32'h0000_0000;
         spawn_kernel <= 32'h0000_0000;
         spawn_cr <= 16'h0000;
         spawn_high_prio <= 1'b0;
         spawn_alt_float <= 1'b0;
         spawn_const_len <= 6'h00;
         spawn_indices <= 128'h0;
      end else if (ce) begin
         clipping_stage_valid <= 1'b0;
         spawn_valid <= 1'b0;
         if (vtx_valid && !flush_req && !enabled) begin
            clipping_stage_valid <= 1'b1;
            clipping_stage_handle <= vtx_handle;
            clipping_stage_header <= vtx_header;
         end else if (vtx_valid && !flush_req && enabled) begin
            if (vcount == 2'h0) begin
               hold0 <= vtx_handle;
            end
            if (vcount == 2'h1) begin
               hold1 <= vtx_handle;
            end
            vcount <= last_vtx ? 2'h0 : vcount + 2'h1;
            if (last_vtx) begin
               spawn_valid <= 1'b1;
               spawn_handle0 <= hold0;
               spawn_handle1 <= hold1;
               spawn_handle2 <= vtx_handle;
               spawn_kernel <= {kernel_ptr, 6'h00};
               spawn_cr <= cr_exc;
               spawn_high_prio <= high_prio;
               spawn_alt_float <= alt_float;
               spawn_const_len <= const_len;
               spawn_indices <= {index[3], index[2], index[1], index[0]};
            end
         end
      end
   end
endmodule

/* bench/gs_front_assertions.sv */
// port checker of the geometry front end
// assumes a bind onto gs_front, one clock domain
`timescale 1ns/1ps
module gs_front_assertions
   import gs_pkg::*;
#(
   parameter int verts_per_object = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic vtx_valid,
   input wire logic [31:0] vtx_handle,
   input wire logic [31:0] vtx_header,
   input wire logic clipping_stage_valid,
   input wire logic [31:0] clipping_stage_handle,
   input wire logic [31:0] clipping_stage_header,
   input wire logic spawn_valid,
   input wire logic [31:0] spawn_handle2,
   input wire logic [31:0] spawn_kernel,
   input wire logic [15:0] spawn_cr,
   input wire logic [127:0] spawn_indices
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****
   // properties
   // ****
   property p_apb_wait; psel && penable && !pready |=> pready; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("pready late");
   property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata outside answer");
   property p_clipping_stage_follow;
      clipping_stage_valid |-> $past(vtx_valid) && clipping_stage_handle == $past(vtx_handle) && clipping_stage_header == $past(vtx_header);
   endproperty
   a_clipping_stage_follow: assert property (p_clipping_stage_follow) else $error("clipping_stage not a copy");
   property p_spawn_cause;
      spawn_valid |-> $past(vtx_valid) && spawn_handle2 == $past(vtx_handle) && !clipping_stage_valid;
   endproperty
   a_spawn_cause: assert property (p_spawn_cause) else $error("spawn without vertex");
   property p_spawn_gap; spawn_valid |=> !spawn_valid [*2]; endproperty
   a_spawn_gap: assert property (p_spawn_gap) else $error("spawn too soon");
   property p_kernel_align; spawn_valid |-> spawn_kernel[5:0] == 6'h00; endproperty
   a_kernel_align: assert property (p_kernel_align) else $error("kernel not 64 byte");
   property p_cr_bits; spawn_valid |-> (spawn_cr & 16'hc7ff) == 16'h0000; endproperty
   a_cr_bits: assert property (p_cr_bits) else $error("stray control bit");
   property p_spawn_hold; !spawn_valid |-> $stable(spawn_indices) && $stable(spawn_kernel); endproperty
   a_spawn_hold: assert property (p_spawn_hold) else $error("spawn data moved");
   c_spawn: cover property (spawn_valid);
   c_clipping_stage: cover property (clipping_stage_valid);
   c_err: cover property (pready && pslverr);
endmodule

/* bench/gs_source.sv */
// model of the command streamer and vertex stage
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module gs_source
   import gs_pkg::*;
(
   input wire logic pclk,
   output logic cmd_valid,
   output logic [31:0] cmd_data,
   output logic vtx_valid,
   output logic [31:0] vtx_handle,
   output logic [31:0] vtx_header
);
   initial begin
      cmd_valid = 1'b0;
      cmd_data = 32'h0;
      vtx_valid = 1'b0;
      vtx_handle = 32'h0;
      vtx_header = 32'h0;
   end
   // ****
   // streams, back to back, released lines inverted
   // ****
   task automatic send_cmd(input logic [31:0] d0, input logic [31:0] d1, input logic [31:0] d2, input logic [31:0] d3);
      logic [31:0] d [4];
      d = '{d0, d1, d2, d3};
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         cmd_valid <= 1'b1;
         cmd_data <= d[i];
      end
      @(posedge pclk);
      cmd_valid <= 1'b0;
      cmd_data <= ~d[3];
   endtask
   // reserved bits zero, length two, max one past last
   task automatic load_index(input logic [1:0] sel, input logic [31:0] value, input logic [31:0] max);
      send_cmd(32'h790b_0002, {1'b0, sel, 29'h0}, value, max);
   endtask
   // idle gap standing for the return buffer fence before a draw
   task automatic fence;
      repeat (2) @(posedge pclk);
   endtask
   task automatic send_vtx(input logic [31:0] base, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         vtx_valid <= 1'b1;
         vtx_handle <= base + 32'(i);
         vtx_header <= ~(base + 32'(i));
      end
      @(posedge pclk);
      vtx_valid <= 1'b0;
      vtx_handle <= ~(base + 32'(n));
      vtx_header <= base + 32'(n);
   endtask
endmodule

/* bench/gs_front_tb.sv */
// self-checking bench of the geometry front end
// assumes gs_source drives the command and vertex streams
`timescale 1ns/1ps
module gs_front_tb
   import gs_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, cmd_valid, vtx_valid, clipping_stage_valid, spawn_valid, spawn_high_prio, spawn_alt_float;
   logic [31:0] prdata, cmd_data, vtx_handle, vtx_header, clipping_stage_handle, clipping_stage_header;
   logic [31:0] spawn_handle0, spawn_handle1, spawn_handle2, spawn_kernel;
   logic [15:0] spawn_cr;
   logic [5:0] spawn_const_len;
   logic [127:0] spawn_indices;
   logic [63:0] clipping_stage_q [$];
   logic [95:0] spawn_q [$];
   logic [31:0] sd [4] = '{32'h1234_5648, 32'h8002_2000, 32'h0001_0405, 32'h5400_0000};
   int num_errors = 0;
   int samples_checked = 0;
   always #50 pclk = ~pclk;
   gs_front dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmd_valid(cmd_valid), .cmd_data(cmd_data), .vtx_valid(vtx_valid), .vtx_handle(vtx_handle),
      .vtx_header(vtx_header), .clipping_stage_valid(clipping_stage_valid), .clipping_stage_handle(clipping_stage_handle), .clipping_stage_header(clipping_stage_header),
      .spawn_valid(spawn_valid), .spawn_handle0(spawn_handle0), .spawn_handle1(spawn_handle1),
      .spawn_handle2(spawn_handle2), .spawn_kernel(spawn_kernel), .spawn_cr(spawn_cr),
      .spawn_high_prio(spawn_high_prio), .spawn_alt_float(spawn_alt_float),
      .spawn_const_len(spawn_const_len), .spawn_indices(spawn_indices));
   gs_source u_src (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .vtx_valid(vtx_valid),
      .vtx_handle(vtx_handle), .vtx_header(vtx_header));
   always @(posedge pclk) begin
      if (clipping_stage_valid === 1'b1) clipping_stage_q.push_back({clipping_stage_handle, clipping_stage_header});
      if (spawn_valid === 1'b1) spawn_q.push_back({spawn_handle0, spawn_handle1, spawn_handle2});
   end
   // ****
   // shared tasks
   // ****
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) num_errors++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r, exp);
      check("slverr", e, 1'b0);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rd_chk(reg_control, control_reset, "control");
      rd_chk(reg_max_index, 32'h0, "max");
      for (int i = 0; i < 4; i++) begin
         rd_chk(reg_index_base + 8'(4 * i), 32'h0, "index");
         wr(reg_kernel + 8'(4 * i), sd[i]);
         rd_chk(reg_kernel + 8'(4 * i), sd[i], "state");
      end
      rd_chk(reg_status, 32'h2, "flow ok");
      apb(1'b0, 8'h40, 32'h0, r, e);
      check("unmapped err", e, 1'b1);
      check("unmapped data", r, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_index;
      logic [31:0] r;
      logic e;
      int n;
      for (int i = 0; i < 4; i++) begin
         u_src.load_index(2'(i), 32'h0300_0000 + 32'(i), 32'h0000_0100 + 32'(i));
         n = 0;
         do begin
            apb(1'b0, reg_index_base + 8'(4 * i), 32'h0, r, e);
            n++;
         end while (r !== 32'h0300_0000 + 32'(i) && n < 20);
         check("index load", r, 32'h0300_0000 + 32'(i));
         rd_chk(reg_max_index, 32'h0000_0100 + 32'(i), "max");
      end
      for (int i = 0; i < 4; i++) begin
         rd_chk(reg_index_base + 8'(4 * i), 32'h0300_0000 + 32'(i), "index kept");
      end
      $display("test index done");
   endtask
   task automatic t_bad;
      logic [31:0] bad [4] = '{32'h590b_0002, 32'h710b_0002, 32'h7a0b_0002, 32'h790c_0002};
      for (int i = 0; i < 4; i++) u_src.send_cmd(bad[i], 32'h0, 32'h0000_0555, 32'h0000_0777);
      repeat (8) @(posedge pclk);
      rd_chk(reg_index_base, 32'h0300_0000, "bad ignored");
      rd_chk(reg_max_index, 32'h0000_0103, "bad max");
      $display("test bad done");
   endtask
   task automatic t_pass;
      wr(reg_control, 32'h0);
      clipping_stage_q.delete();
      spawn_q.delete();
      u_src.send_vtx(32'h0000_0a10, 4);
      repeat (3) @(posedge pclk);
      check("clipping_stage count", clipping_stage_q.size(), 4);
      for (int i = 0; i < 4; i++) check("clipping_stage", clipping_stage_q[i], {32'ha10 + 32'(i), ~(32'ha10 + 32'(i))});
      check("no spawn", spawn_q.size(), 0);
      ce <= 1'b0;
      u_src.send_vtx(32'h0000_0c00, 2);
      ce <= 1'b1;
      repeat (3) @(posedge pclk);
      check("frozen clipping_stage", clipping_stage_q.size(), 4);
      $display("test pass done");
   endtask
   task automatic t_spawn(input logic [31:0] d1, input logic [15:0] cr, input logic hp, input logic af);
      wr(reg_flags, d1);
      wr(reg_control, 32'h1);
      u_src.fence();
      clipping_stage_q.delete();
      spawn_q.delete();
      u_src.send_vtx(32'h0000_0b20, 6);
      repeat (3) @(posedge pclk);
      check("spawn count", spawn_q.size(), 2);
      for (int i = 0; i < 2; i++) begin
         check("spawn", spawn_q[i], {32'hb20 + 32'(3 * i), 32'hb21 + 32'(3 * i), 32'hb22 + 32'(3 * i)});
      end
      check("no clipping_stage", clipping_stage_q.size(), 0);
      check("kernel", spawn_kernel, 32'h1234_5640);
      check("cr", spawn_cr, cr);
      check("prio", spawn_high_prio, hp);
      check("float", spawn_alt_float, af);
      check("const len", spawn_const_len, 6'h2a);
      check("indices", spawn_indices, {32'h0300_0003, 32'h0300_0002, 32'h0300_0001, 32'h0300_0000});
      $display("test spawn done");
   endtask
   task automatic t_zero;
      u_src.load_index(2'h3, 32'h0, 32'h0);
      rd_chk(reg_index_base + 8'hc, 32'h0, "index zero");
      $display("test zero done");
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_index;
      t_bad;
      t_pass;
      t_spawn(32'h8002_2000, 16'h1000, 1'b1, 1'b0);
      t_spawn(32'h8001_0880, 16'h2800, 1'b0, 1'b1);
      t_zero;
      give_verdict;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      give_verdict;
   end
endmodule
bind gs_front gs_front_assertions #(.verts_per_object(verts_per_object)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vtx_valid(vtx_valid),
   .vtx_handle(vtx_handle), .vtx_header(vtx_header), .clipping_stage_valid(clipping_stage_valid), .clipping_stage_handle(clipping_stage_handle),
   .clipping_stage_header(clipping_stage_header), .spawn_valid(spawn_valid), .spawn_handle2(spawn_handle2),
   .spawn_kernel(spawn_kernel), .spawn_cr(spawn_cr), .spawn_indices(spawn_indices));
